// ---- bench/ccp_value_register_pair_tb_top.sv ----
// self-checking bench for the capture/compare/pwm value register pair
`timescale 1ns/1ps
module ccp_value_register_pair_tb_top;
   // ==========================================
   // stimulus and observed signals
   logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, cap = 1'h0;
   logic [3:0] aw = 4'h0, ar = 4'h0;
   logic [31:0] wd = 32'h0;
   logic [15:0] tb = 16'h0;
   logic awr, wr_rdy, bv, arr, rv, match;
   logic [1:0] bresp, rresp;
   logic [31:0] rd;
   logic [9:0] pw;
   int fail_count = 0, check_count = 0;
   localparam logic [1:0] ok = ccp_value_pkg::resp_okay;
   typedef struct {logic [7:0] ctl, lo, hi; logic [9:0] w;} row_t;
   // pwm rows: control, low byte, high byte, expected width
   row_t rows [4] = '{'{8'h03, 8'ha5, 8'hff, 10'h3a5}, '{8'h13, 8'h7f, 8'h5a, 10'h169},
      '{8'h03, 8'h00, 8'hfc, 10'h000}, '{8'h13, 8'h3f, 8'h00, 10'h000}};
   ccp_value_register_pair i_ccp_value_register_pair (.aclk(aclk), .aresetn(aresetn), .clk_en(1'h1),
      .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .timebase_count(tb), .capture_event(cap),
      .compare_match(match), .pulse_width_value(pw));
   initial begin
      forever #25 aclk = ~aclk;
   end
   // ==========================================
   // report and bus tasks
   task wrap_up;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
      int n = 0;
      aw <= a; wd <= {24'h0, d}; awv <= 1'h1; wv <= 1'h1; br <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (awr) awv <= 1'h0;
         if (wr_rdy) wv <= 1'h0;
      end while (!bv && n < 40);
      if (!bv) fail_count++;
      if (!bv) wrap_up();
      chk({30'h0, bresp}, {30'h0, er});
   endtask : wr
   task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
      int n = 0;
      ar <= a; arv <= 1'h1; rr <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
         if (arr) arv <= 1'h0;
      end while (!rv && n < 40);
      if (!rv) fail_count++;
      if (!rv) wrap_up();
      chk(rd, e);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : rdc
   // ==========================================
   // main sequence
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk({22'h0, pw}, 32'h0);
      rdc(4'h0, 32'h0, ok);
      rdc(4'h4, 32'h0, ok);
      foreach (rows[i]) begin
         wr(4'h8, rows[i].ctl, ok);
         wr(4'h0, rows[i].lo, ok);
         wr(4'h4, rows[i].hi, ok);
         @(posedge aclk);
         chk({22'h0, pw}, {22'h0, rows[i].w});
         rdc(4'hc, {22'h0, rows[i].w}, ok);
         rdc(4'h0, {24'h0, rows[i].lo}, ok);
         rdc(4'h4, {24'h0, rows[i].hi}, ok);
      end
      // flip alignment only: same bytes read as right-aligned
      wr(4'h8, 8'h03, ok);
      @(posedge aclk);
      chk({22'h0, pw}, 32'h3f);
      rdc(4'h0, 32'h3f, ok);
      // capture the timebase into the pair
      wr(4'h8, 8'h01, ok);
      tb <= 16'hbeef;
      cap <= 1'h1;
      @(posedge aclk);
      cap <= 1'h0;
      @(posedge aclk);
      rdc(4'h0, 32'hef, ok);
      rdc(4'h4, 32'hbe, ok);
      // compare against the captured pair
      wr(4'h8, 8'h02, ok);
      tb <= 16'hbeee;
      repeat (2) @(posedge aclk);
      chk({31'h0, match}, 32'h0);
      tb <= 16'hbeef;
      repeat (2) @(posedge aclk);
      chk({31'h0, match}, 32'h1);
      // status is read-only
      wr(4'hc, 8'hff, ccp_value_pkg::resp_slverr);
      rdc(4'h0, 32'hef, ok);
      // reset in mid-run clears the pair
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk({31'h0, match}, 32'h0);
      rdc(4'h0, 32'h0, ok);
      rdc(4'h4, 32'h0, ok);
      wrap_up();
   end
endmodule : ccp_value_register_pair_tb_top

// ---- core/ccp_value_pkg.sv ----
// constants for the capture/compare/pwm value register pair
package ccp_value_pkg;
   // ==========================================
   // register byte addresses
   localparam logic [3:0] low_byte_addr = 4'h0;
   localparam logic [3:0] high_byte_addr = 4'h4;
   localparam logic [3:0] control_addr = 4'h8;
   localparam logic [3:0] status_addr = 4'hc;
   // ==========================================
   // reset values and field positions
   localparam logic [7:0] byte_reset = 8'h00;
   localparam int alignment_bit_pos = 4;
   localparam int mode_lsb = 0;
   localparam int mode_msb = 1;
   localparam logic [1:0] resp_okay = 2'b00;
   localparam logic [1:0] resp_slverr = 2'b10;
   // ==========================================
   // channel modes
   typedef enum logic [1:0] {
      mode_off_t_v,
      mode_capture,
      mode_compare,
      mode_pwm
   } chan_mode_t;
endpackage : ccp_value_pkg

// ---- core/ccp_value_register_pair.sv ----
// value register pair of one capture/compare/pwm channel with an axi4-lite slave
// ==========================================
// Notes on behaviour
// - capture loads timebase count into both bytes
// - compare matches timebase against the byte pair
// - right-aligned width bits 7:0 from low byte
// - right-aligned bits 9:8 from high 1:0
// - left-aligned: high byte 9:2, low 7:6
// - bytes read/write, clear on every reset
// - control bit 4 selects width alignment
//
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module ccp_value_register_pair #(
   parameter int count_width = 16
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // axi4-lite write
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timebase and events
   input wire logic [count_width-1:0] timebase_count,
   input wire logic capture_event,
   // channel results
   output logic compare_match,
   output logic [9:0] pulse_width_value
);
   // ==========================================
   // state
   logic [7:0] low_q, low_d, high_q, high_d;
   logic [1:0] mode_q, mode_d;
   logic align_q, align_d;
   logic match_q, match_d;
   logic [9:0] width_q, width_d;
   logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, ar_q, ar_d, rv_q, rv_d;
   logic awrdy_q, awrdy_d, wrdy_q, wrdy_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [3:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

   function automatic logic known_addr(input logic [3:0] a);
      known_addr = (a == ccp_value_pkg::low_byte_addr) || (a == ccp_value_pkg::high_byte_addr) ||
                   (a == ccp_value_pkg::control_addr) || (a == ccp_value_pkg::status_addr);
   endfunction : known_addr

   // ==========================================
   // next-state logic
   always_comb begin
      logic do_write;
      do_write = 1'b0;
      low_d = low_q;
      high_d = high_q;
      mode_d = mode_q;
      align_d = align_q;
      aw_d = aw_q;
      w_d = w_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      awrdy_d = awrdy_q;
      wrdy_d = wrdy_q;
      bv_d = bv_q;
      bresp_d = bresp_q;
      ar_d = ar_q;
      rv_d = rv_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      // write channels: each is taken when its valid meets its ready
      if (s_axi_awvalid && awrdy_q) begin
         aw_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wrdy_q) begin
         w_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      // the response follows once both halves are held
      if (aw_d && w_d) begin
         do_write = 1'b1;
         aw_d = 1'b0;
         w_d = 1'b0;
         bv_d = 1'b1;
         bresp_d = known_addr(awaddr_d) && awaddr_d != ccp_value_pkg::status_addr ?
                   ccp_value_pkg::resp_okay : ccp_value_pkg::resp_slverr;
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      // ready only while idle, so a held valid is never taken twice
      awrdy_d = !aw_d && !bv_d;
      wrdy_d = !w_d && !bv_d;
      // capture loads the pair; a software write to the low or high byte in the same cycle wins for that byte
      if (mode_q == ccp_value_pkg::mode_capture && capture_event) begin
         high_d = timebase_count[15:8];
         low_d = timebase_count[7:0];
      end
      if (do_write && wstrb_d[0]) begin
         if (awaddr_d == ccp_value_pkg::low_byte_addr) begin
            low_d = wdata_d[7:0];
         end
         if (awaddr_d == ccp_value_pkg::high_byte_addr) begin
            high_d = wdata_d[7:0];
         end
         if (awaddr_d == ccp_value_pkg::control_addr) begin
            align_d = wdata_d[ccp_value_pkg::alignment_bit_pos];
            mode_d = wdata_d[ccp_value_pkg::mode_msb:ccp_value_pkg::mode_lsb];
         end
      end
      // read channel: data and response stand until rready
      if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      if (s_axi_arvalid && ar_q) begin
         rv_d = 1'b1;
         rresp_d = known_addr(s_axi_araddr) ? ccp_value_pkg::resp_okay : ccp_value_pkg::resp_slverr;
         case (s_axi_araddr)
            ccp_value_pkg::low_byte_addr: rdata_d = {24'h000000, low_q};
            ccp_value_pkg::high_byte_addr: rdata_d = {24'h000000, high_q};
            ccp_value_pkg::control_addr: rdata_d = {27'h0000000, align_q, 2'b00, mode_q};
            ccp_value_pkg::status_addr: rdata_d = {21'h000000, match_q, width_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
      ar_d = !rv_d;
   end

   // pulse width and compare from the stored bytes
   always_comb begin
      if (align_q) begin
         width_d = {high_q, low_q[7:6]};
      end else begin
         width_d = {high_q[1:0], low_q};
      end
      match_d = (mode_q == ccp_value_pkg::mode_compare) && (timebase_count[15:0] == {high_q, low_q});
   end

   // ==========================================
   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         low_q <= ccp_value_pkg::byte_reset;
         high_q <= ccp_value_pkg::byte_reset;
         mode_q <= 2'b00;
         align_q <= 1'b0;
         match_q <= 1'b0;
         width_q <= 10'h000;
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         awrdy_q <= 1'b0;
         wrdy_q <= 1'b0;
         bv_q <= 1'b0;
         bresp_q <= 2'b00;
         ar_q <= 1'b0;
         rv_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= 2'b00;
      end else if (clk_en) begin
         low_q <= low_d;
         high_q <= high_d;
         mode_q <= mode_d;
         align_q <= align_d;
         match_q <= match_d;
         width_q <= width_d;
         aw_q <= aw_d;
         w_q <= w_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         awrdy_q <= awrdy_d;
         wrdy_q <= wrdy_d;
         bv_q <= bv_d;
         bresp_q <= bresp_d;
         ar_q <= ar_d;
         rv_q <= rv_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // readies are high while the channel is idle and drop once it is taken
   assign s_axi_awready = awrdy_q;
   assign s_axi_wready = wrdy_q;
   assign s_axi_bvalid = bv_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ar_q;
   assign s_axi_rvalid = rv_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign compare_match = match_q;
   assign pulse_width_value = width_q;

   // ==========================================
   // assertions
   capture_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && mode_q == ccp_value_pkg::mode_capture && capture_event && !(bv_d && !bv_q)
      |=> {high_q, low_q} == $past(timebase_count[15:0]))
      else $error("capture did not load pair");
   compare_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en |=> compare_match == ($past(mode_q) == ccp_value_pkg::mode_compare &&
                                   $past(timebase_count[15:0]) == $past({high_q, low_q})))
      else $error("compare match wrong");
   right_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && !align_q |=> pulse_width_value[7:0] == $past(low_q))
      else $error("right width low wrong");
   right_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && !align_q |=> pulse_width_value[9:8] == $past(high_q[1:0]))
      else $error("right width high wrong");
   left_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && align_q |=> pulse_width_value == {$past(high_q), $past(low_q[7:6])})
      else $error("left width wrong");
   reset_clear_a: assert property (@(posedge aclk)
      !aresetn |=> low_q == 8'h00 && high_q == 8'h00)
      else $error("pair not cleared");
   align_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && bv_d && !bv_q && awaddr_d == ccp_value_pkg::control_addr && wstrb_d[0]
      |=> align_q == $past(wdata_d[4]))
      else $error("alignment bit not stored");
   realign_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      clk_en && align_d != align_q && !(mode_q == ccp_value_pkg::mode_capture && capture_event)
      |=> $stable({high_q, low_q}))
      else $error("realign altered bytes");
   cov_capture_c: cover property (@(posedge aclk) mode_q == ccp_value_pkg::mode_capture && capture_event);
   cov_match_c: cover property (@(posedge aclk) compare_match);
   cov_left_c: cover property (@(posedge aclk) align_q && mode_q == ccp_value_pkg::mode_pwm);
endmodule : ccp_value_register_pair
